/* include/keo_pkg.sv */
// shared constants for the kernel return, queue load, flush, load and store unit
package keo_pkg;
   localparam int ADDR_W = 32;
   localparam int REG_IDX_W = 6;
   localparam logic [3:0] OPC_KRET = 4'h2;
   localparam logic [3:0] OPC_QLOAD = 4'h3;
   localparam logic [3:0] OPC_FLUSH = 4'h4;
   localparam logic [3:0] OPC_LOAD = 4'h5;
   localparam logic [3:0] OPC_STORE = 4'h6;
   localparam int OPC_LSB = 28;
   localparam int DREG_LSB = 22;
   localparam int BREG_LSB = 16;
   localparam int DISP_W = 16;
   localparam logic [31:0] FLUSH_STEP = 32'h0000_0004;
   localparam int PAGE_W = 10;
   localparam logic [31:0] PC_QUEUE_RST = 32'h0000_0000;
   localparam logic [31:0] FETCH_RST = 32'h0000_0000;
   typedef enum logic [4:0] {
      KEO_RUN = 5'h01,
      KEO_FLUSH = 5'h02,
      KEO_STALL = 5'h04,
      KEO_TRAP = 5'h08,
      KEO_WAIT = 5'h10
   } keo_state_e;
endpackage : keo_pkg

/* design/keo_ea_gen.sv */
// effective word address: base register shifted right by two plus signed displacement
`timescale 1ns/1ps
module keo_ea_gen (
   input wire logic [31:0] baseVal,
   input wire logic [15:0] disp,
   output logic [31:0] effAddr
);
   always_comb begin
      effAddr = (baseVal >> 2) + {{16{disp[15]}}, disp};
   end
endmodule : keo_ea_gen

/* design/keo_hazard.sv */
// one-cycle stall detection for base-register and store adjacency hazards
`timescale 1ns/1ps
module keo_hazard (
   input wire logic decMem,
   input wire logic decIsLoad,
   input wire logic [5:0] decBase,
   input wire logic prevValid,
   input wire logic prevWritesReg,
   input wire logic [5:0] prevDest,
   input wire logic prevIsStore,
   output logic stall
);
   always_comb begin
      stall = decMem && prevValid &&
         ((prevWritesReg && prevDest == decBase) || prevIsStore);
      if (decIsLoad && prevValid && prevIsStore) begin
         stall = 1'b1;
      end
   end
endmodule : keo_hazard

/* design/keo_exec_unit.sv */
// execution control for kernel return, queue load, flush, load and store
// Behaviour
// RQ1 - kernel return: fetch = older + disp, newer to older, own address to newer; the code sets fetch to older shifted right two plus disp
// RQ2 - the instruction after a kernel return executes before the redirect
// RQ3 - new status applies at second kernel return decode; kernel bit at first user decode
// RQ4 - kernel return, queue load, flush in user mode raise illegal-instruction trap
// RQ5 - kernel must ensure older queue address has a valid instruction translation
// RQ6 - queue load: address to fetch reg, to pc in execute, queued in writeback
// RQ7 - software follows every queue load with a branch
// RQ8 - queue load must not miss in instruction cache during execute
// RQ9 - flush invalidates both cache lines from address to end of page
// RQ10 - dirty data lines are written back before invalidation
// RQ11 - each flush step flushes fetch address then adds four
// RQ12 - flush address should be a multiple of eight plus one
// RQ13 - software follows each flush with a branch
// RQ14 - instruction before flush is not a store nor writes its base
// RQ15 - load: address in decode, read in execute, register write in writeback
// RQ16 - load translation miss traps; older holds load, newer next address
// RQ17 - trapping load leaves its destination register unchanged
// RQ18 - stall one cycle on base hazard, and for load after store
// RQ19 - store: address in decode, probe in execute, cache write in writeback
// RQ20 - store translation miss traps; queue holds store and next address
// RQ21 - write-protected page on store gives write protection trap
// RQ22 - either store trap suppresses the cache write
// RQ23 - store followed by load or store stalls one cycle
// RQ24 - effective address is base shifted right two plus signed displacement
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module keo_exec_unit #(
   parameter int PAGE_BITS = keo_pkg::PAGE_W
) (
   input wire logic core_clk,
   input wire logic rst_b,
   // decode-stage instruction
   input wire logic decValid,
   input wire logic [31:0] decInstr,
   input wire logic [31:0] decPc,
   input wire logic [31:0] nextPc,
   input wire logic [31:0] baseVal,
   input wire logic [31:0] storeData,
   // previous instruction, for the hazard check
   input wire logic prevWritesReg,
   input wire logic [5:0] prevDest,
   // status
   input wire logic statusKernel,
   input wire logic statusMapOn,
   input wire logic statusWritePending,
   // data translation
   input wire logic dtlbHit,
   input wire logic dtlbWriteOk,
   // caches and memory
   input wire logic [31:0] memReadData,
   input wire logic dirtyLine,
   input wire logic wbDone,
   output logic stall,
   output logic [31:0] fetchAddress,
   output logic fetchRedirect,
   output logic [31:0] pcQueueOlder,
   output logic [31:0] pcQueueNewer,
   output logic [31:0] dataAddress,
   output logic dataRead,
   output logic dataProbe,
   output logic dataWrite,
   output logic [31:0] dataWriteData,
   output logic flushLine,
   output logic flushWriteBack,
   output logic regWrite,
   output logic [5:0] regWriteIdx,
   output logic [31:0] regWriteData,
   output logic illegalTrap,
   output logic dataXlateTrap,
   output logic writeProtTrap,
   output logic statusApply,
   output logic kernelClear
);
   // the end-of-page test needs at least three word-index bits
   if (PAGE_BITS < 3 || PAGE_BITS > 30) begin : gPageCheck
      $error("keo_exec_unit: PAGE_BITS out of range");
   end

   typedef struct packed {
      keo_pkg::keo_state_e state;
      logic [31:0] fetch;
      logic [31:0] older;
      logic [31:0] newer;
      logic [31:0] pcLatch;
      logic [31:0] dAddr;
      logic [31:0] result;
      logic [31:0] sData;
      logic [31:0] exPc;
      logic [31:0] exNext;
      logic [5:0] exDest;
      logic exLoad;
      logic exStore;
      logic exQload;
      logic wrLoad;
      logic wrStore;
      logic wrQload;
      logic [5:0] wrDest;
      logic prevValid;
      logic prevStore;
      logic kretSeen;
      logic kretPending;
      logic redirect;
      logic illegal;
      logic xlate;
      logic wprot;
      logic stApply;
      logic kClear;
   } keo_st_s;

   keo_st_s st_r;
   keo_st_s st_nxt;

   logic [3:0] opc;
   logic [5:0] dReg;
   logic [5:0] bReg;
   logic [15:0] disp;
   logic [31:0] effAddr;
   logic [31:0] kretTarget;
   logic isKret;
   logic isQload;
   logic isFlush;
   logic isLoad;
   logic isStore;
   logic isPriv;
   logic hazStall;
   logic flushLast;
   logic [PAGE_BITS-1:0] ones;

   assign opc = decInstr[keo_pkg::OPC_LSB +: 4];
   assign dReg = decInstr[keo_pkg::DREG_LSB +: keo_pkg::REG_IDX_W];
   assign bReg = decInstr[keo_pkg::BREG_LSB +: keo_pkg::REG_IDX_W];
   assign disp = decInstr[keo_pkg::DISP_W-1:0];
   assign isKret = decValid && opc == keo_pkg::OPC_KRET;
   assign isQload = decValid && opc == keo_pkg::OPC_QLOAD;
   assign isFlush = decValid && opc == keo_pkg::OPC_FLUSH;
   assign isLoad = decValid && opc == keo_pkg::OPC_LOAD;
   assign isStore = decValid && opc == keo_pkg::OPC_STORE;
   assign isPriv = isKret || isQload || isFlush;
   assign ones = '1;
   // last step of the page: index within the final four words, so the next step wraps and flushing stops
   assign flushLast = st_r.fetch[PAGE_BITS-1:0] >= (ones - PAGE_BITS'(3));

   // [RQ24]
   keo_ea_gen uEa (
      .baseVal(baseVal),
      .disp(disp),
      .effAddr(effAddr)
   );

   // same word form, but from the older queue entry [RQ1]
   keo_ea_gen uKret (
      .baseVal(st_r.older),
      .disp(disp),
      .effAddr(kretTarget)
   );

   // [RQ18] [RQ23]
   keo_hazard uHaz (
      .decMem(isLoad || isStore),
      .decIsLoad(isLoad),
      .decBase(bReg),
      .prevValid(st_r.prevValid),
      .prevWritesReg(prevWritesReg),
      .prevDest(prevDest),
      .prevIsStore(st_r.prevStore),
      .stall(hazStall)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.redirect = 1'b0;
      st_nxt.illegal = 1'b0;
      st_nxt.xlate = 1'b0;
      st_nxt.wprot = 1'b0;
      st_nxt.stApply = 1'b0;
      st_nxt.kClear = 1'b0;
      st_nxt.wrLoad = 1'b0;
      st_nxt.wrStore = 1'b0;
      st_nxt.wrQload = 1'b0;
      st_nxt.exLoad = 1'b0;
      st_nxt.exStore = 1'b0;
      st_nxt.exQload = 1'b0;

      // writeback stage
      if (st_r.wrQload) begin
         st_nxt.older = st_r.newer; // [RQ6]
         st_nxt.newer = st_r.pcLatch; // [RQ6]
      end

      // execute stage
      if (st_r.exQload) begin
         st_nxt.pcLatch = st_r.fetch; // [RQ6]
         st_nxt.wrQload = 1'b1;
      end
      if (st_r.exLoad) begin
         if (statusMapOn && !dtlbHit) begin
            st_nxt.xlate = 1'b1; // [RQ16]
            st_nxt.older = st_r.exPc; // [RQ16]
            st_nxt.newer = st_r.exNext; // [RQ16]
         end else begin
            st_nxt.result = memReadData; // [RQ15]
            st_nxt.wrLoad = 1'b1;
            st_nxt.wrDest = st_r.exDest;
         end
      end
      if (st_r.exStore) begin
         if (statusMapOn && !dtlbHit) begin
            st_nxt.xlate = 1'b1; // [RQ20]
            st_nxt.older = st_r.exPc; // [RQ20]
            st_nxt.newer = st_r.exNext; // [RQ20]
         end else if (statusMapOn && !dtlbWriteOk) begin
            st_nxt.wprot = 1'b1; // [RQ21]
            st_nxt.older = st_r.exPc; // [RQ21]
            st_nxt.newer = st_r.exNext; // [RQ21]
         end else begin
            st_nxt.wrStore = 1'b1; // [RQ22]
         end
      end

      unique case (st_r.state)
         keo_pkg::KEO_RUN: begin
            if (decValid) begin
               st_nxt.prevValid = 1'b1;
               st_nxt.prevStore = isStore;
            end else begin
               // a bubble means the next access no longer follows the last one
               st_nxt.prevValid = 1'b0;
               st_nxt.prevStore = 1'b0;
            end
            if (st_r.kretPending && decValid && !isKret) begin
               st_nxt.kClear = 1'b1; // [RQ3]
               st_nxt.kretPending = 1'b0;
            end
            if (isPriv && !statusKernel) begin
               st_nxt.illegal = 1'b1; // [RQ4]
               st_nxt.prevStore = 1'b0;
            end else if (hazStall) begin
               // held for exactly one cycle: with the history cleared decode takes it next edge
               st_nxt.prevValid = 1'b0; // [RQ18] [RQ23]
               st_nxt.prevStore = 1'b0;
            end else if (isKret) begin
               // redirect reaches fetch after the following slot [RQ2]
               st_nxt.fetch = kretTarget; // [RQ1]
               st_nxt.older = st_r.newer; // [RQ1]
               st_nxt.newer = decPc; // [RQ1]
               st_nxt.redirect = 1'b1; // [RQ2]
               if (st_r.kretSeen && statusWritePending) begin
                  st_nxt.stApply = 1'b1; // [RQ3]
               end
               st_nxt.kretSeen = 1'b1;
               st_nxt.kretPending = 1'b1;
            end else if (isQload) begin
               st_nxt.fetch = effAddr; // [RQ6]
               st_nxt.exQload = 1'b1;
               st_nxt.kretSeen = 1'b0;
            end else if (isFlush) begin
               st_nxt.fetch = effAddr; // [RQ24]
               st_nxt.state = keo_pkg::KEO_FLUSH;
               st_nxt.kretSeen = 1'b0;
            end else if (isLoad || isStore) begin
               st_nxt.dAddr = effAddr; // [RQ15] [RQ19]
               st_nxt.exLoad = isLoad;
               st_nxt.exStore = isStore;
               st_nxt.exPc = decPc;
               st_nxt.exNext = nextPc;
               st_nxt.exDest = dReg;
               st_nxt.sData = storeData;
               st_nxt.kretSeen = 1'b0;
            end else if (decValid) begin
               st_nxt.kretSeen = 1'b0;
            end
         end
         keo_pkg::KEO_STALL: begin
            // one bubble, then decode retries the same instruction
            st_nxt.state = keo_pkg::KEO_RUN;
         end
         keo_pkg::KEO_FLUSH: begin
            if (dirtyLine) begin
               st_nxt.state = keo_pkg::KEO_WAIT; // [RQ10]
            end else begin
               st_nxt.fetch = st_r.fetch + keo_pkg::FLUSH_STEP; // [RQ11]
               if (flushLast) begin
                  st_nxt.state = keo_pkg::KEO_RUN; // [RQ9]
               end
            end
         end
         keo_pkg::KEO_WAIT: begin
            // invalidate only after the dirty line has reached memory
            if (wbDone) begin
               st_nxt.fetch = st_r.fetch + keo_pkg::FLUSH_STEP; // [RQ11]
               st_nxt.state = flushLast ? keo_pkg::KEO_RUN : keo_pkg::KEO_FLUSH; // [RQ9]
            end
         end
         keo_pkg::KEO_TRAP: begin
            st_nxt.state = keo_pkg::KEO_RUN;
         end
         default: begin
            st_nxt.state = keo_pkg::KEO_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.state <= keo_pkg::KEO_RUN;
         st_r.fetch <= keo_pkg::FETCH_RST;
         st_r.older <= keo_pkg::PC_QUEUE_RST;
         st_r.newer <= keo_pkg::PC_QUEUE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign stall = hazStall || st_r.state != keo_pkg::KEO_RUN;
   assign fetchAddress = st_r.fetch;
   assign fetchRedirect = st_r.redirect;
   assign pcQueueOlder = st_r.older;
   assign pcQueueNewer = st_r.newer;
   assign dataAddress = st_r.dAddr;
   assign dataRead = st_r.exLoad; // [RQ15]
   assign dataProbe = st_r.exStore; // [RQ19]
   assign dataWrite = st_r.wrStore; // [RQ19] [RQ22]
   assign dataWriteData = st_r.sData;
   assign flushLine = (st_r.state == keo_pkg::KEO_FLUSH && !dirtyLine) ||
      (st_r.state == keo_pkg::KEO_WAIT && wbDone); // [RQ10]
   assign flushWriteBack = st_r.state == keo_pkg::KEO_FLUSH && dirtyLine; // [RQ10]
   // a trapped load never reaches writeback, so its target keeps its value
   assign regWrite = st_r.wrLoad; // [RQ17]
   assign regWriteIdx = st_r.wrDest;
   assign regWriteData = st_r.result;
   assign illegalTrap = st_r.illegal;
   assign dataXlateTrap = st_r.xlate;
   assign writeProtTrap = st_r.wprot;
   assign statusApply = st_r.stApply;
   assign kernelClear = st_r.kClear;
endmodule : keo_exec_unit

/* tb/keo_exec_unit_properties.sv */
// concurrent checks on the execution unit ports
`timescale 1ns/1ps
module keo_exec_unit_properties (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic decValid,
   input wire logic [31:0] decInstr,
   input wire logic [31:0] decPc,
   input wire logic [31:0] baseVal,
   input wire logic [31:0] storeData,
   input wire logic prevWritesReg,
   input wire logic [5:0] prevDest,
   input wire logic statusKernel,
   input wire logic statusMapOn,
   input wire logic dtlbHit,
   input wire logic dtlbWriteOk,
   input wire logic stall,
   input wire logic [31:0] fetchAddress,
   input wire logic fetchRedirect,
   input wire logic [31:0] pcQueueOlder,
   input wire logic [31:0] pcQueueNewer,
   input wire logic [31:0] dataAddress,
   input wire logic dataRead,
   input wire logic dataProbe,
   input wire logic dataWrite,
   input wire logic [31:0] dataWriteData,
   input wire logic flushLine,
   input wire logic regWrite,
   input wire logic [5:0] regWriteIdx,
   input wire logic illegalTrap,
   input wire logic dataXlateTrap,
   input wire logic writeProtTrap
);
   logic [3:0] opc;
   logic take;
   logic memOp;
   logic priv;
   logic [31:0] ea;
   logic stTook_r;
   assign opc = decInstr[31:28];
   assign take = decValid && !stall;
   assign memOp = opc == keo_pkg::OPC_LOAD || opc == keo_pkg::OPC_STORE;
   assign priv = opc == keo_pkg::OPC_KRET || opc == keo_pkg::OPC_QLOAD || opc == keo_pkg::OPC_FLUSH;
   assign ea = (baseVal >> 2) + {{16{decInstr[15]}}, decInstr[15:0]};
   // remembers an accepted store for the adjacency stall
   always_ff @(posedge core_clk) begin
      stTook_r <= rst_b && take && opc == keo_pkg::OPC_STORE;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence ldGo; take && opc == keo_pkg::OPC_LOAD; endsequence
   sequence stGo; take && opc == keo_pkg::OPC_STORE; endsequence
   AST_LOAD_READ: assert property (ldGo |=> dataRead && dataAddress == $past(ea))
      else $error("load read missing or misaddressed");
   AST_LOAD_WB: assert property (ldGo ##1 (!statusMapOn || dtlbHit) |=> regWrite
      && regWriteIdx == $past(decInstr[27:22], 2)) else $error("load result not written");
   AST_LOAD_TRAP: assert property (ldGo ##1 (statusMapOn && !dtlbHit)
      |=> dataXlateTrap && !regWrite) else $error("load miss handled wrongly");
   AST_STORE_PROBE: assert property (stGo |=> dataProbe && dataAddress == $past(ea))
      else $error("store probe missing or misaddressed");
   AST_STORE_WRITE: assert property (stGo ##1 (!statusMapOn || (dtlbHit && dtlbWriteOk))
      |=> dataWrite && dataWriteData == $past(storeData, 2)) else $error("store write wrong");
   AST_STORE_PROT: assert property (stGo ##1 (statusMapOn && dtlbHit
      && !dtlbWriteOk) |=> writeProtTrap && !dataWrite)
      else $error("protected store handled wrongly");
   AST_STORE_MISS: assert property (stGo ##1 (statusMapOn && !dtlbHit)
      |=> dataXlateTrap && !dataWrite) else $error("store miss handled wrongly");
   AST_PRIV: assert property (take && !statusKernel && priv |-> ##[1:2] illegalTrap)
      else $error("no illegal trap in user mode");
   AST_KRET_QUEUE: assert property (take && statusKernel && opc == keo_pkg::OPC_KRET
      |=> fetchRedirect && pcQueueOlder == $past(pcQueueNewer) && pcQueueNewer == $past(decPc))
      else $error("kernel return queue shift wrong");
   AST_BASE_STALL: assert property (decValid && memOp && prevWritesReg
      && prevDest == decInstr[21:16] && !$past(stall) |-> stall) else $error("no base stall");
   AST_STORE_NEXT: assert property (stTook_r && decValid && memOp |-> stall)
      else $error("no stall after store");
   AST_FLUSH_STEP: assert property (flushLine |=> fetchAddress == $past(fetchAddress)
      + keo_pkg::FLUSH_STEP) else $error("flush step not four");
endmodule : keo_exec_unit_properties

bind keo_exec_unit keo_exec_unit_properties keo_exec_unit_properties_i (.*);

/* tb/keo_mem_model.sv */
// cache and memory side: read data, one dirty line, slow write-back
`timescale 1ns/1ps
module keo_mem_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic dataRead,
   input wire logic [31:0] dataAddress,
   input wire logic [31:0] fetchAddress,
   input wire logic flushWriteBack,
   output logic [31:0] memReadData,
   output logic dirtyLine,
   output logic wbDone
);
   logic [31:0] junk;
   logic [1:0] wbCnt;
   logic cleaned;
   // outside a read the bus churns so a stale word cannot pass as data
   assign memReadData = dataRead ? {dataAddress[15:0], ~dataAddress[15:0]} : junk;
   assign dirtyLine = fetchAddress[3:0] == 4'h5 && !cleaned;
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         junk <= 32'h5a5a_0f0f;
         wbCnt <= 2'h0;
         wbDone <= 1'b0;
         cleaned <= 1'b0;
      end else begin
         junk <= {junk[30:0], ~junk[31]};
         // the unit asks for a write-back for one cycle only; the count then runs by itself
         wbCnt <= (flushWriteBack || wbCnt != 2'h0) ? wbCnt + 2'h1 : 2'h0;
         wbDone <= wbCnt == 2'h2;
         cleaned <= cleaned || wbDone;
      end
   end
endmodule : keo_mem_model

/* tb/test_kernel_exit_flush_load_store_ops.sv */
// self-checking bench for the execution unit
`timescale 1ns/1ps
module test_kernel_exit_flush_load_store_ops;
   logic core_clk, rst_b, decValid, prevWritesReg, statusKernel, statusMapOn, statusWritePending;
   logic dtlbHit, dtlbWriteOk, dirtyLine, wbDone, stall, fetchRedirect, dataRead, dataProbe;
   logic dataWrite, flushLine, flushWriteBack, regWrite, illegalTrap, dataXlateTrap;
   logic writeProtTrap, statusApply, kernelClear;
   logic [31:0] decInstr, decPc, nextPc, baseVal, storeData, memReadData, fetchAddress;
   logic [31:0] pcQueueOlder, pcQueueNewer, dataAddress, dataWriteData, regWriteData;
   logic [31:0] lastReg, pcCnt, mark;
   logic [5:0] prevDest, regWriteIdx;
   int bad_count, n_compared, cycles, nIll, nXl, nProt, nWr, nRw, nStall, nFl, nWb, nApl, nClr;
   keo_exec_unit #(.PAGE_BITS(4)) keo_exec_unit_i (.*);
   keo_mem_model keo_mem_model_i (.*);
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task conclude();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // holds the instruction until decode takes it
   task issue(input logic [3:0] op, input logic [5:0] d, input logic [5:0] b,
      input logic [15:0] dp);
      decInstr <= {op, d, b, dp};
      decValid <= 1'b1;
      decPc <= pcCnt;
      nextPc <= pcCnt + 32'h4;
      do @(posedge core_clk); while (stall === 1'b1);
      pcCnt = pcCnt + 32'h4;
   endtask : issue
   task idle(input int n);
      decValid <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask : idle
   always @(posedge core_clk) begin
      cycles++;
      if (illegalTrap === 1'b1) nIll++;
      if (dataXlateTrap === 1'b1) nXl++;
      if (writeProtTrap === 1'b1) nProt++;
      if (dataWrite === 1'b1) nWr++;
      if (flushLine === 1'b1) nFl++;
      if (wbDone === 1'b1) nWb++;
      if (statusApply === 1'b1) nApl++;
      if (kernelClear === 1'b1) nClr++;
      if (stall === 1'b1 && decValid) nStall++;
      if (regWrite === 1'b1) nRw++;
      if (regWrite === 1'b1) lastReg = regWriteData;
      if (cycles == 3000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      rst_b = 1'b0;
      decValid = 1'b0;
      decInstr = 32'h0;
      decPc = 32'h0;
      nextPc = 32'h0;
      baseVal = 32'h0;
      storeData = 32'h0;
      prevWritesReg = 1'b0;
      prevDest = 6'h0;
      statusKernel = 1'b0;
      statusMapOn = 1'b0;
      statusWritePending = 1'b0;
      dtlbHit = 1'b1;
      dtlbWriteOk = 1'b1;
      pcCnt = 32'h100;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      cmp(pcQueueOlder, keo_pkg::PC_QUEUE_RST);
      for (int i = 0; i < 3; i++) begin
         issue(keo_pkg::OPC_KRET + i[3:0], 6'h0, 6'h0, 16'h0);
         idle(3);
      end
      cmp(nIll, 3);
      cmp(fetchAddress, keo_pkg::FETCH_RST);
      $display("test privilege done");
      statusKernel <= 1'b1;
      statusWritePending <= 1'b1;
      baseVal <= 32'h400;
      mark = pcCnt;
      issue(keo_pkg::OPC_KRET, 6'h0, 6'h0, 16'h0010);
      issue(keo_pkg::OPC_KRET, 6'h0, 6'h0, 16'h0020);
      statusWritePending <= 1'b0;
      issue(keo_pkg::OPC_LOAD, 6'h07, 6'h03, 16'hfff0);
      idle(4);
      cmp(pcQueueOlder, mark);
      cmp(pcQueueNewer, mark + 32'h4);
      cmp(fetchAddress, 32'h20);
      cmp(lastReg, 32'h00f0_ff0f);
      cmp(nApl, 1);
      cmp(nClr, 1);
      $display("test kernel return done");
      statusMapOn <= 1'b1;
      dtlbHit <= 1'b0;
      mark = pcCnt;
      issue(keo_pkg::OPC_LOAD, 6'h03, 6'h03, 16'h0);
      idle(4);
      cmp(nXl, 1);
      cmp(pcQueueOlder, mark);
      cmp(pcQueueNewer, mark + 32'h4);
      cmp(nRw, 1);
      $display("test load trap done");
      dtlbHit <= 1'b1;
      storeData <= 32'hcafe_0001;
      issue(keo_pkg::OPC_LOAD, 6'h03, 6'h05, 16'h0);
      prevWritesReg <= 1'b1;
      prevDest <= 6'h03;
      issue(keo_pkg::OPC_STORE, 6'h02, 6'h03, 16'h0);
      prevWritesReg <= 1'b0;
      issue(keo_pkg::OPC_STORE, 6'h02, 6'h05, 16'h0001);
      issue(keo_pkg::OPC_LOAD, 6'h04, 6'h05, 16'h0);
      idle(4);
      cmp(nStall, 3);
      cmp(nWr, 2);
      cmp(dataWriteData, 32'hcafe_0001);
      cmp(nRw, 3);
      dtlbWriteOk <= 1'b0;
      mark = pcCnt;
      issue(keo_pkg::OPC_STORE, 6'h02, 6'h05, 16'h0);
      idle(4);
      cmp(nProt, 1);
      cmp(pcQueueOlder, mark);
      dtlbHit <= 1'b0;
      dtlbWriteOk <= 1'b1;
      mark = pcCnt;
      issue(keo_pkg::OPC_STORE, 6'h02, 6'h05, 16'h0);
      idle(4);
      cmp(nXl, 2);
      cmp(pcQueueNewer, mark + 32'h4);
      cmp(nWr, 2);
      $display("test stores done");
      statusMapOn <= 1'b0;
      dtlbHit <= 1'b1;
      baseVal <= 32'h800;
      mark = pcQueueNewer;
      issue(keo_pkg::OPC_QLOAD, 6'h0, 6'h0a, 16'h0004);
      idle(4);
      cmp(pcQueueNewer, 32'h204);
      cmp(pcQueueOlder, mark);
      $display("test queue load done");
      baseVal <= 32'h40;
      idle(1);
      issue(keo_pkg::OPC_FLUSH, 6'h0, 6'h01, 16'h0001);
      idle(1);
      for (int i = 0; i < 60 && nFl < 4; i++) @(posedge core_clk);
      idle(3);
      cmp(nFl, 4);
      cmp(nWb, 1);
      cmp(fetchAddress, 32'h21);
      $display("test flush done");
      conclude();
   end
endmodule : test_kernel_exit_flush_load_store_ops
